//--- shared/ccd_map.svh
// Purpose: constants for the cycle state decoder
// Assumes: 50 MHz system clock
// Notes:   counts derive from clock rates by expression
`ifndef CCD_MAP_SVH
`define CCD_MAP_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define CCD_CLK_HZ        50000000
`define CCD_MASTER_HZ     1000000
`define CCD_PHASE_HZ      (`CCD_MASTER_HZ / 2)
`define CCD_PHASE_CYC     (`CCD_CLK_HZ / `CCD_PHASE_HZ)
`define CCD_PH_ON_CYC     (`CCD_PHASE_CYC * 2 / 5)
`define CCD_PH2_START     (`CCD_PHASE_CYC / 2)
`define CCD_CLEAR_PERIODS 16
// ----------------------------------------
// Opcodes and fields
// ----------------------------------------
`define CCD_HALT_OP       8'h00
`define CCD_CT_HI_BIT     6
`define CCD_CT_LO_BIT     7
`define CCD_SEL_RAM       2'h0
`define CCD_SEL_ROM       2'h1
`define CCD_SEL_IO        2'h2
`define CCD_PORT_BA0      3'h0
`define CCD_PORT_BA1      3'h1
`define CCD_PORT_BA2      3'h2
`define CCD_PORT_SW0      3'h3
`define CCD_PORT_SW1      3'h4
`define CCD_PORT_BCR      3'h5
`define CCD_BCR_HALT      0
`define CCD_BCR_INIT      1
`define CCD_BCR_DBUS      2
`define CCD_BCR_MSYN      3
`endif

//--- shared/ccd_pkg.sv
// Purpose: types for the cycle state decoder
// Assumes: nothing
// Notes:   state codes are the line triple zero,one,two
package ccd_pkg;
	typedef enum logic [2:0] {
		CCD_ADDR_LOW  = 3'b010,
		CCD_INTR_LOW  = 3'b011,
		CCD_ADDR_HIGH = 3'b001,
		CCD_WAIT      = 3'b000,
		CCD_FETCH     = 3'b100,
		CCD_STOPPED   = 3'b110,
		CCD_EXEC_A    = 3'b111,
		CCD_EXEC_B    = 3'b101
	} ccd_tstate_t;
	typedef enum logic [1:0] {
		CCD_CT_FETCH = 2'b00,
		CCD_CT_READ  = 2'b01,
		CCD_CT_IO    = 2'b10,
		CCD_CT_WRITE = 2'b11
	} ccd_ctype_t;
endpackage

//--- core/ccd_top.sv
// Purpose: cycle sequencer, time state decoder and satellite registers
// Assumes: data bus pin is asynchronous and passes two flip-flops
// Notes:   one time state is two phase periods of the derived clocks
`include "ccd_map.svh"

// How it works
// - three state lines decode into eight states
// - bits six and seven give cycle type
// - cycle type captured in address high state
// - first cycle of instruction is a fetch
// - low then high byte form address
// - transfer in fetch, execute in exec states
// - exec states skipped, cycle length varies
// - normal cycle runs five states then repeats
// - five bit shift counter, instruction picks feedback
// - program counter increments in address low state
// - power rise forces halt opcode and stop
// - sixteen clock periods of clearing, then ready
// - decoded halt restarts at zero after sixteen
// - address register loads low, then high byte
// - bus address register loads in fetch only
// - switch register loads in fetch only
// - data bus control decodes RAM, ROM, port
// - bus control register loads when selected in an I/O cycle, a type the sequencer never sets
// - data moves as eight bit bytes
// - stack of program counter and seven returns
// - two nonoverlapping half rate phase clocks
// - separate clears for address and other registers
module ccd_top (
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        arst_n_in,
	// Pins from outside
	input  wire logic        power_rise_in,
	input  wire logic [7:0]  data_bus_in,
	// Phase clocks and sequencer view
	output logic             phase1_out,
	output logic             phase2_out,
	output logic             sync_out,
	output logic             state_line_zero_out,
	output logic             state_line_one_out,
	output logic             state_line_two_out,
	output logic [7:0]       seq_bus_out,
	output logic [13:0]      pc_out,
	output logic [7:0]       instr_out,
	// Decoded states and cycle type
	output logic [7:0]       state_strobe_out,
	output logic             read_data_cycle_out,
	output logic             io_command_cycle_out,
	output logic             write_data_cycle_out,
	// Satellite registers
	output logic [15:0]      addr_reg_out,
	output logic [19:0]      bus_addr_out,
	output logic [15:0]      switch_out,
	output logic             ram_ctl_out,
	output logic             rom_en_out,
	output logic             halt_req_out,
	output logic             bus_init_out,
	output logic             data_to_bus_out,
	output logic             master_sync_out,
	// Power-up
	output logic             addr_clear_out,
	output logic             reg_clear_out,
	output logic             start_intr_out,
	output logic             ready_out
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Cycles an opcode needs; feedback choice of the state counter
	function automatic logic [1:0] ncyc_f(input logic [7:0] op);
		if (op[7:6] == 2'b01 && (op[2:0] == 3'b100 || op[2:0] == 3'b110))
			ncyc_f = 2'd3;
		else if (op[7:6] == 2'b00 && op[2:0] == 3'b110)
			ncyc_f = 2'd2;
		else
			ncyc_f = 2'd1;
	endfunction

	// One-hot line per state code, used for strobes
	function automatic logic [7:0] onehot_f(input logic [2:0] code);
		onehot_f = 8'h01 << code;
	endfunction

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [7:0]  bus_m_q;
	logic [7:0]  bus_s_q;
	logic        pr_m_q;
	logic        pr_s_q;
	logic        pr_d_q;

	// Two flops per pin; the second is read, and power rise also reads a third for its edge
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			bus_m_q <= 8'h00;
			bus_s_q <= 8'h00;
			pr_m_q  <= 1'b0;
			pr_s_q  <= 1'b0;
			pr_d_q  <= 1'b0;
		end else begin
			bus_m_q <= data_bus_in;
			bus_s_q <= bus_m_q;
			pr_m_q  <= power_rise_in;
			pr_s_q  <= pr_m_q;
			pr_d_q  <= pr_s_q;
		end
	end

	// ----------------------------------------
	// Phase clocks and time state pacing
	// ----------------------------------------
	logic [6:0]  ph_cnt_q;
	logic        half_q;
	wire  logic  ph_end = (ph_cnt_q == 7'(`CCD_PHASE_CYC - 1));
	wire  logic  ts_adv = ph_end & half_q;

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ph_cnt_q <= 7'h00;
			half_q   <= 1'b0;
		end else begin
			ph_cnt_q <= ph_end ? 7'h00 : ph_cnt_q + 7'd1;
			half_q   <= half_q ^ ph_end;
		end
	end

	// Gap between windows keeps the phases from overlapping
	assign phase1_out = (ph_cnt_q < 7'(`CCD_PH_ON_CYC));
	assign phase2_out = (ph_cnt_q >= 7'(`CCD_PH2_START)) &&
		(ph_cnt_q < 7'(`CCD_PH2_START + `CCD_PH_ON_CYC));
	assign sync_out   = ~half_q;

	// ----------------------------------------
	// Power-up and halt restart
	// ----------------------------------------
	logic        pu_q;
	logic        halt_q;
	logic        ready_q;
	logic        intr_q;
	logic [4:0]  clr_cnt_q;
	wire  logic  clearing  = pu_q | halt_q;
	wire  logic  clr_done  = clearing & ph_end &
		(clr_cnt_q == 5'(`CCD_CLEAR_PERIODS - 1));
	wire  logic  pwr_edge  = pr_s_q & ~pr_d_q;

	// Power rise restarts the sequence even mid-operation
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pu_q      <= 1'b0;
			ready_q   <= 1'b0;
			intr_q    <= 1'b0;
			clr_cnt_q <= 5'h00;
		end else begin
			intr_q <= clr_done & pu_q;
			if (pwr_edge) begin
				pu_q      <= 1'b1;
				ready_q   <= 1'b0;
				clr_cnt_q <= 5'h00;
			end else if (clr_done) begin
				pu_q      <= 1'b0;
				ready_q   <= 1'b1;
				clr_cnt_q <= 5'h00;
			end else if (clearing && ph_end) begin
				clr_cnt_q <= clr_cnt_q + 5'd1;
			end
		end
	end

	assign addr_clear_out = pu_q;
	assign reg_clear_out  = clearing;
	assign start_intr_out = intr_q;
	assign ready_out      = ready_q;

	// ----------------------------------------
	// State counter and instruction flow
	// ----------------------------------------
	logic [4:0]  sh_q;
	logic [1:0]  cyc_q;
	logic [7:0]  ir_q;
	logic [7:0]  opr_lo_q;
	logic [5:0]  opr_hi_q;
	logic [2:0]  sp_q;
	logic [13:0] stack_q [8];
	wire  logic       run  = ready_q & ~clearing;
	wire  logic [7:0] op   = (cyc_q == 2'd0) ? bus_s_q : ir_q;
	wire  logic       last = (cyc_q == ncyc_f(op) - 2'd1);
	wire  logic [13:0] tgt = {opr_hi_q, opr_lo_q}; // Pin moves on after fetch, so both bytes are held
	wire  logic [13:0] pc  = stack_q[sp_q];
	wire  logic       is_jmp = ir_q[7:6] == 2'b01 && ir_q[2:0] == 3'b100;
	wire  logic       is_cal = ir_q[7:6] == 2'b01 && ir_q[2:0] == 3'b110;
	wire  logic       is_ret = ir_q[7:6] == 2'b00 && ir_q[2:0] == 3'b111;
	wire  logic       at_t3  = run & ts_adv & sh_q[2];
	wire  logic       at_t5  = run & ts_adv & sh_q[4];

	// Stack cleared with the other registers on halt restart
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sh_q  <= 5'h01;
			cyc_q <= 2'd0;
			ir_q  <= 8'h00;
			opr_lo_q <= 8'h00;
			opr_hi_q <= 6'h00;
			sp_q  <= 3'd0;
			halt_q <= 1'b0;
			for (int i = 0; i < 8; i++)
				stack_q[i] <= 14'h0000;
		end else if (clearing) begin
			sh_q  <= 5'h01;
			cyc_q <= 2'd0;
			if (pu_q)
				ir_q <= `CCD_HALT_OP;
			if (clr_done) begin
				halt_q <= 1'b0;
				sp_q   <= 3'd0;
				for (int i = 0; i < 8; i++)
					stack_q[i] <= 14'h0000;
			end
		end else if (run && ts_adv) begin
			if (sh_q[0])
				stack_q[sp_q] <= pc + 14'd1;
			if (sh_q[2] && !last) begin
				sh_q  <= 5'h01;
				cyc_q <= cyc_q + 2'd1;
			end else begin
				sh_q <= {sh_q[3:0], sh_q[4]};
			end
			if (at_t3) begin
				if (cyc_q == 2'd0) begin
					ir_q <= bus_s_q;
					halt_q <= (bus_s_q == `CCD_HALT_OP);
				end
				if (cyc_q == 2'd1)
					opr_lo_q <= bus_s_q;
				if (cyc_q == 2'd2)
					opr_hi_q <= bus_s_q[5:0];
			end
			if (at_t5) begin
				cyc_q <= 2'd0;
				if (is_jmp)
					stack_q[sp_q] <= tgt;
				if (is_cal) begin
					sp_q <= sp_q + 3'd1;
					stack_q[sp_q + 3'd1] <= tgt;
				end
				if (is_ret)
					sp_q <= sp_q - 3'd1;
			end
		end
	end

	// ----------------------------------------
	// State lines and processor bus bytes
	// ----------------------------------------
	ccd_pkg::ccd_tstate_t ts;
	ccd_pkg::ccd_ctype_t  seq_ct;
	logic [7:0]  seq_bus_q;
	wire  logic [13:0] pc_lag = pc - 14'd1; // Counter already stepped at end of addr_low

	// The shift counter's active bit names the time state
	always_comb begin
		ts = ccd_pkg::CCD_WAIT;
		if (clearing)
			ts = ccd_pkg::CCD_STOPPED;
		else if (ready_q) begin
			case (1'b1)
				sh_q[0]: ts = ccd_pkg::CCD_ADDR_LOW;
				sh_q[1]: ts = ccd_pkg::CCD_ADDR_HIGH;
				sh_q[2]: ts = ccd_pkg::CCD_FETCH;
				sh_q[3]: ts = ccd_pkg::CCD_EXEC_A;
				default: ts = ccd_pkg::CCD_EXEC_B;
			endcase
		end
	end

	assign seq_ct = (cyc_q == 2'd0) ? ccd_pkg::CCD_CT_FETCH
		: ccd_pkg::CCD_CT_READ;
	assign state_line_zero_out = ts[2];
	assign state_line_one_out  = ts[1];
	assign state_line_two_out  = ts[0];

	// Bus byte lags the state by one clock, well inside it
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in)
			seq_bus_q <= 8'h00;
		else if (ts == ccd_pkg::CCD_ADDR_LOW)
			seq_bus_q <= pc[7:0];
		else if (ts == ccd_pkg::CCD_ADDR_HIGH)
			seq_bus_q <= {seq_ct[0], seq_ct[1], pc_lag[13:8]};
		else
			seq_bus_q <= bus_s_q;
	end

	assign seq_bus_out = seq_bus_q;
	assign pc_out      = pc;
	assign instr_out   = ir_q;

	// ----------------------------------------
	// Time state decoder and cycle type
	// ----------------------------------------
	logic [7:0]  strobe_q;
	logic [1:0]  ct_q;
	wire  logic  st_start = (ph_cnt_q == 7'h00) & ~half_q;
	wire  logic  s_low  = strobe_q[ccd_pkg::CCD_ADDR_LOW] |
		strobe_q[ccd_pkg::CCD_INTR_LOW];
	wire  logic  s_high = strobe_q[ccd_pkg::CCD_ADDR_HIGH];
	wire  logic  s_ftch = strobe_q[ccd_pkg::CCD_FETCH];

	// Strobes change only at the start of sync's high half
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			strobe_q <= 8'h00;
			ct_q     <= 2'b00;
		end else begin
			if (st_start)
				strobe_q <= onehot_f(ts);
			if (ts_adv && s_high)
				ct_q <= {seq_bus_q[`CCD_CT_HI_BIT],
					seq_bus_q[`CCD_CT_LO_BIT]};
		end
	end

	assign state_strobe_out     = strobe_q;
	assign read_data_cycle_out  = (ct_q == ccd_pkg::CCD_CT_READ);
	assign io_command_cycle_out = (ct_q == ccd_pkg::CCD_CT_IO);
	assign write_data_cycle_out = (ct_q == ccd_pkg::CCD_CT_WRITE);

	// ----------------------------------------
	// Address register and data bus control
	// ----------------------------------------
	logic [15:0] addr_q;
	logic [19:0] ba_q;
	logic [15:0] sw_q;
	logic [7:0]  bcr_q;
	wire  logic [1:0] sel  = addr_q[15:14];
	wire  logic [2:0] port = addr_q[2:0];
	wire  logic  io_ld = ts_adv & s_ftch & (sel == `CCD_SEL_IO) &
		io_command_cycle_out;

	// Address register has its own clear
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in)
			addr_q <= 16'h0000;
		else if (pu_q)
			addr_q <= 16'h0000;
		else if (ts_adv && s_low)
			addr_q[7:0] <= seq_bus_q;
		else if (ts_adv && s_high)
			addr_q[15:8] <= seq_bus_q;
	end

	// Port registers load only at the end of fetch_state
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ba_q  <= 20'h0_0000;
			sw_q  <= 16'h0000;
			bcr_q <= 8'h00;
		end else if (clearing) begin
			ba_q  <= 20'h0_0000;
			sw_q  <= 16'h0000;
			bcr_q <= 8'h00;
		end else if (io_ld) begin
			if (port == `CCD_PORT_BA0)
				ba_q[7:0] <= bus_s_q;
			else if (port == `CCD_PORT_BA1)
				ba_q[15:8] <= bus_s_q;
			else if (port == `CCD_PORT_BA2)
				ba_q[19:16] <= bus_s_q[3:0];
			else if (port == `CCD_PORT_SW0)
				sw_q[7:0] <= bus_s_q;
			else if (port == `CCD_PORT_SW1)
				sw_q[15:8] <= bus_s_q;
			else if (port == `CCD_PORT_BCR)
				bcr_q <= bus_s_q;
		end
	end

	assign addr_reg_out    = addr_q;
	assign bus_addr_out    = ba_q;
	assign switch_out      = sw_q;
	assign ram_ctl_out     = s_ftch & (sel == `CCD_SEL_RAM);
	assign rom_en_out      = s_ftch & (sel == `CCD_SEL_ROM);
	assign halt_req_out    = bcr_q[`CCD_BCR_HALT];
	assign bus_init_out    = bcr_q[`CCD_BCR_INIT];
	assign data_to_bus_out = bcr_q[`CCD_BCR_DBUS];
	assign master_sync_out = bcr_q[`CCD_BCR_MSYN];
endmodule

//--- verif/ccd_top_sva.sv
// Purpose: port assertions for the cycle state decoder
// Assumes: one clock domain, asynchronous active low reset
// Notes:   strobe bit index equals the state line code
// ----------------------------------------
// Checker
// ----------------------------------------
module ccd_top_sva (
	// Clock and reset
	input wire logic        clock_in,
	input wire logic        arst_n_in,
	// Pins from outside
	input wire logic        power_rise_in,
	// Phases and state lines
	input wire logic        phase1_out,
	input wire logic        phase2_out,
	input wire logic        sync_out,
	input wire logic        state_line_zero_out,
	input wire logic        state_line_one_out,
	input wire logic        state_line_two_out,
	input wire logic [7:0]  state_strobe_out,
	// Registers and control
	input wire logic [15:0] addr_reg_out,
	input wire logic        ram_ctl_out,
	input wire logic        rom_en_out,
	// Power-up
	input wire logic        addr_clear_out,
	input wire logic        reg_clear_out,
	input wire logic        start_intr_out,
	input wire logic        ready_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] code;
	// Line zero is the top bit of the code
	assign code = {state_line_zero_out, state_line_one_out, state_line_two_out};
	default clocking @(posedge clock_in); endclocking
	default disable iff (!arst_n_in);
	// Relations between the decoded ports, each tied to its cause
	a_phase_apart: assert property (!(phase1_out && phase2_out))
		else $error("phase clocks overlap");
	a_strobe_state: assert property (ready_out && $past(ready_out, 200) && !reg_clear_out
		&& $fell(sync_out) |-> state_strobe_out == (8'h01 << code))
		else $error("strobe does not match state lines");
	a_clear_stopped: assert property (addr_clear_out |-> code == 3'b110 && !ready_out)
		else $error("not stopped while clearing");
	a_ready_after: assert property ($fell(addr_clear_out) |-> ##[0:1] ready_out)
		else $error("ready missing after clear");
	a_pwr_clear: assert property ($rose(power_rise_in) |-> ##[1:6] addr_clear_out && reg_clear_out)
		else $error("supply rise gave no clear");
	a_intr_pulse: assert property (start_intr_out |=> !start_intr_out)
		else $error("start interrupt longer than one cycle");
	a_intr_only_power: assert property (start_intr_out |-> $past(addr_clear_out) || $past(addr_clear_out, 2))
		else $error("start interrupt outside power-up");
	a_mem_sel_fetch: assert property (ram_ctl_out || rom_en_out
		|-> state_strobe_out[4] && !(ram_ctl_out && rom_en_out))
		else $error("memory select outside fetch");
	a_addr_low_load: assert property ($changed(addr_reg_out[7:0]) && !addr_clear_out
		&& !$past(addr_clear_out) |-> $past(state_strobe_out[2]) || $past(state_strobe_out[2], 2))
		else $error("low address byte loaded outside its state");
	a_addr_high_load: assert property ($changed(addr_reg_out[15:8]) && !addr_clear_out
		&& !$past(addr_clear_out) |-> $past(state_strobe_out[1]) || $past(state_strobe_out[1], 2))
		else $error("high address byte loaded outside its state");
endmodule

bind ccd_top ccd_top_sva chk (.clock_in, .arst_n_in, .power_rise_in, .phase1_out, .phase2_out, .sync_out,
	.state_line_zero_out, .state_line_one_out, .state_line_two_out, .state_strobe_out, .addr_reg_out,
	.ram_ctl_out, .rom_en_out, .addr_clear_out, .reg_clear_out, .start_intr_out, .ready_out);

//--- verif/ccd_prog_mem.sv
// Purpose: program memory on the far side of the data pin
// Assumes: address register holds the fetch address in fetch state
// Notes:   pin toggles outside fetch so a stale byte never looks valid
module ccd_prog_mem (
	// Clock
	input  wire logic        clock_in,
	// Sequencer view
	input  wire logic [2:0]  state_code_in,
	input  wire logic [13:0] addr_in,
	// Data pin
	output logic [7:0]       data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [64];
	// Default fill is a one-byte move, harmless if fetched
	initial begin
		foreach (mem[i]) mem[i] = 8'hc0;
		data_out = 8'h00;
	end
	// Whole bytes from consecutive places; junk between fetches
	always @(posedge clock_in) begin
		if (state_code_in == 3'b100) data_out <= mem[addr_in[5:0]];
		else data_out <= ~data_out;
	end
endmodule

//--- verif/ccd_top_test.sv
// Purpose: self-checking bench for the cycle state decoder
// Assumes: program memory model drives the data pin
// Notes:   states are sampled half way through each time state
module ccd_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clock_in, arst_n_in, power_rise_in, sync_out, ready_out;
	logic        state_line_zero_out, state_line_one_out, state_line_two_out;
	logic        read_data_cycle_out, io_command_cycle_out, write_data_cycle_out;
	logic        addr_clear_out, reg_clear_out, start_intr_out, ram_ctl_out, rom_en_out;
	logic        halt_req_out, bus_init_out, data_to_bus_out, master_sync_out;
	logic [19:0] bus_addr_out;
	logic [15:0] switch_out;
	logic [13:0] pc_out;
	logic [7:0]  data_bus_in, state_strobe_out, instr_out;
	logic [15:0] addr_reg_out;
	logic [2:0]  code;
	int          fails, n_checks, cyc, n, n_intr;
	// Row: code and read flag on top, fetch address below
	logic [19:0] rows [43] = '{20'h4_0000, 20'h2_0000, 20'h8_0000, 20'he_0000, 20'ha_0000,
		20'h4_0000, 20'h2_0000, 20'h8_0001, 20'h4_0000, 20'h2_0000, 20'h9_0002, 20'h4_0000, 20'h2_0000,
		20'h9_0003, 20'he_0000, 20'ha_0000, 20'h4_0000, 20'h2_0000, 20'h8_0010, 20'h4_0000, 20'h2_0000,
		20'h9_0011, 20'he_0000, 20'ha_0000, 20'h4_0000, 20'h2_0000, 20'h8_0012, 20'h4_0000, 20'h2_0000,
		20'h9_0013, 20'h4_0000, 20'h2_0000, 20'h9_0014, 20'he_0000, 20'ha_0000, 20'h4_0000, 20'h2_0000,
		20'h8_0020, 20'he_0000, 20'ha_0000, 20'h4_0000, 20'h2_0000, 20'h8_0015};
	assign code = {state_line_zero_out, state_line_one_out, state_line_two_out};
	ccd_top dut (.clock_in, .arst_n_in, .power_rise_in, .data_bus_in, .phase1_out(), .phase2_out(),
		.sync_out, .state_line_zero_out, .state_line_one_out, .state_line_two_out, .seq_bus_out(),
		.pc_out, .instr_out, .state_strobe_out, .read_data_cycle_out, .io_command_cycle_out,
		.write_data_cycle_out, .addr_reg_out, .bus_addr_out, .switch_out, .ram_ctl_out,
		.rom_en_out, .halt_req_out, .bus_init_out, .data_to_bus_out, .master_sync_out,
		.addr_clear_out, .reg_clear_out, .start_intr_out, .ready_out);
	ccd_prog_mem mem_i (.clock_in, .state_code_in(code), .addr_in(addr_reg_out[13:0]), .data_out(data_bus_in));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic ticks(input int k);
		repeat (k) @(negedge clock_in);
	endtask
	// Clock, hang guard and interrupt pulse count
	initial begin
		clock_in = 0;
		forever #10 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			results();
		end
	end
	always @(negedge clock_in) if (start_intr_out === 1'b1) n_intr++;
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		arst_n_in = 0;
		power_rise_in = 0;
		repeat (16) @(posedge clock_in);
		@(negedge clock_in);
		check({5'h00, code, state_strobe_out}, 16'h0000);
		check({15'h0, ready_out}, 16'h0000);
		// Jump at one, load at ten hex, call at twelve hex, return at twenty hex, halt at fifteen hex
		mem_i.mem[1] = 8'h44;
		mem_i.mem[2] = 8'h10;
		mem_i.mem[3] = 8'h00;
		mem_i.mem[16] = 8'h06;
		mem_i.mem[17] = 8'h55;
		mem_i.mem[18] = 8'h46;
		mem_i.mem[19] = 8'h20;
		mem_i.mem[20] = 8'h00;
		mem_i.mem[21] = 8'h00;
		mem_i.mem[32] = 8'h07;
		@(posedge clock_in) #2 arst_n_in = 1;
		repeat (3) @(posedge clock_in) #2 power_rise_in = 1;
		$display("test reset done");
		for (n = 0; n < 20 && addr_clear_out !== 1'b1; n++) ticks(1);
		check({5'h00, code, instr_out}, 16'h0600);
		for (n = 0; n < 2000 && ready_out !== 1'b1; n++) ticks(1);
		check(16'(n >= 1580 && n <= 1700), 16'h0001);
		check({15'h0, addr_clear_out}, 16'h0000);
		$display("test power-up done");
		for (n = 0; n < 400 && code !== 3'b010; n++) ticks(1);
		foreach (rows[i]) begin
			ticks(i == 0 ? 100 : 200);
			check({13'h0, code}, {13'h0, rows[i][19:17]});
			check({8'h00, state_strobe_out}, 16'h0001 << rows[i][19:17]);
			if (rows[i][19:17] == 3'b100) begin
				check({2'b00, addr_reg_out[13:0]}, {2'b00, rows[i][13:0]});
				check({2'b00, pc_out}, {2'b00, rows[i][13:0] + 14'd1});
				check({14'h0, ram_ctl_out, rom_en_out}, {14'h0, ~rows[i][16], 1'b0});
				check({13'h0, read_data_cycle_out, io_command_cycle_out, write_data_cycle_out},
					{13'h0, rows[i][16], 2'b00});
			end
		end
		check({15'h0, |{bus_addr_out, switch_out, halt_req_out, bus_init_out, data_to_bus_out,
			master_sync_out}}, 16'h0000);
		$display("test program trace done");
		for (n = 0; n < 1000 && reg_clear_out !== 1'b1; n++) ticks(1);
		check({15'h0, addr_clear_out}, 16'h0000);
		for (n = 0; n < 2000 && reg_clear_out === 1'b1; n++) ticks(1);
		check(16'(n >= 1580 && n <= 1700), 16'h0001);
		for (n = 0; n < 2000 && code !== 3'b100; n++) ticks(1);
		ticks(100);
		check({2'b00, addr_reg_out[13:0]}, 16'h0000);
		check(16'(n_intr), 16'h0001);
		$display("test halt restart done");
		@(posedge clock_in) #2 arst_n_in = 0;
		ticks(2);
		check({7'h00, ready_out, state_strobe_out}, 16'h0000);
		@(posedge clock_in) #2 arst_n_in = 1;
		for (n = 0; n < 20 && addr_clear_out !== 1'b1; n++) ticks(1);
		check({5'h00, code, 7'h00, ready_out}, 16'h0600);
		$display("test mid-run reset done");
		results();
	end
endmodule
